//--- src/rscf_top.sv
// Behaviour
// - any active reset source drives the system reset output active
// - seven sources: power-on, brown-out, pin, instruction, watchdog, trap, bad operation
// - each reset kind sets its own flag in the cause register
// - power-on clears all flags except the power-on and brown-out flags at bits 0 and 1
// - software may write any flag; writing never causes a reset
// - bit 15 set by trap conflict, cleared by power-on, brown-out or software
// - bit 14 set by bad operation, cleared by power-on or brown-out
// - bit 7 set by pin reset, cleared by power-on or software, not brown-out
// - bit 6 set by reset instruction, cleared by power-on or brown-out
// - bit 4 set by watchdog time-out, cleared by power-saving, power-on, brown-out
// - bit 3 set on entering sleep, cleared by power-on or brown-out
// - bit 2 set on entering idle, cleared by power-on or brown-out
// - bit 1 set by brown-out or power-on, cleared only by software
// - bit 0 set by power-on; after power-on register reads 0x0003
// - bit 5 enables watchdog; unprogrammed fuse keeps watchdog on regardless
// - bit 8 keeps regulator active in sleep; zero lets it stand by
// - bits 13 to 9 always read as zero
// - control bits keep their value through every reset except power-on
// - pin, watchdog, software, trap, bad-operation resets hold about 20 us
// - after power-up release waits for the power-on delay, then the power-up timer with the regulator off or the start-up delay with it on
//
// Strobed register access and the placing of the registers were decided locally.
module rscf_top
  import rscf_pkg::*;
#(
  parameter int unsigned POWER_UP_TIMER_CYC = rscf_pkg::POWER_UP_TIMER_CYC_DEF
)
(
  // clock, reset, enable
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  input wire logic CE_I,
  // reset sources
  input wire logic BROWN_OUT_RESET_I,
  input wire logic MASTER_CLEAR_PIN_I,
  input wire logic RESET_INSTR_I,
  input wire logic WATCHDOG_TIMEOUT_I,
  input wire logic TRAP_CONFLICT_I,
  input wire logic BAD_OPERATION_I,
  // power-saving instruction events
  input wire logic POWER_SAVING_SLEEP_I,
  input wire logic POWER_SAVING_IDLE_I,
  // configuration
  input wire logic WATCHDOG_FUSE_ENABLE_I,
  input wire logic REGULATOR_ENABLE_I,
  // register port
  input wire logic [rscf_pkg::RSCF_AW-1:0] ADDR_I,
  input wire logic [rscf_pkg::RSCF_DW-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [rscf_pkg::RSCF_DW-1:0] RDATA_O,
  // system outputs
  output logic SYSTEM_RESET_OUT_O,
  output logic WATCHDOG_ENABLE_O,
  output logic REGULATOR_SLEEP_KEEP_O
);
  import rscf_pkg::*;

  // ==========================================================
  // source decode
  logic [15:0] rcc_r;
  logic [15:0] rcc_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  rscf_state_t state_r;
  rscf_state_t state_nxt;
  logic [RSCF_CW-1:0] cnt_r;
  logic [RSCF_CW-1:0] cnt_nxt;
  logic sys_rst_r;
  logic sys_rst_nxt;
  logic wdt_en_r;
  logic wdt_en_nxt;
  logic vreg_r;
  wire hold_src;
  wire any_src;
  wire wr_hit;
  wire rd_hit;
  wire power_saving_instruction;
  wire [15:0] set_v;
  wire [15:0] clr_v;
  wire [15:0] base_v;
  wire [RSCF_CW-1:0] start_cyc;
  wire [RSCF_CW-1:0] long_load;
  wire [RSCF_CW-1:0] trst_load;

  assign hold_src = MASTER_CLEAR_PIN_I | RESET_INSTR_I | WATCHDOG_TIMEOUT_I
                  | TRAP_CONFLICT_I | BAD_OPERATION_I;
  assign any_src = hold_src | BROWN_OUT_RESET_I;
  assign power_saving_instruction = POWER_SAVING_SLEEP_I | POWER_SAVING_IDLE_I;
  assign wr_hit = WR_I && (ADDR_I == RCC_OFS);
  assign rd_hit = RD_I && (ADDR_I == RCC_OFS);

  // ==========================================================
  // cause flags
  // every source has its own bit, so sources in one cycle all land
  assign set_v = (TRAP_CONFLICT_I ? rscf_bit(B_TRAP) : RCC_ZERO)
               | (BAD_OPERATION_I ? rscf_bit(B_BAD) : RCC_ZERO)
               | (MASTER_CLEAR_PIN_I ? rscf_bit(B_EXT) : RCC_ZERO)
               | (RESET_INSTR_I ? rscf_bit(B_SWR) : RCC_ZERO)
               | (WATCHDOG_TIMEOUT_I ? rscf_bit(B_WATCHDOG_TIMEOUT_FLAG) : RCC_ZERO)
               | (POWER_SAVING_SLEEP_I ? rscf_bit(B_SLEEP) : RCC_ZERO)
               | (POWER_SAVING_IDLE_I ? rscf_bit(B_IDLE) : RCC_ZERO)
               | (BROWN_OUT_RESET_I ? rscf_bit(B_BOR) : RCC_ZERO);

  // brown-out spares the pin flag, the brown-out flag and the controls
  assign clr_v = (BROWN_OUT_RESET_I ? RCC_BOR_CLR : RCC_ZERO)
               | (power_saving_instruction ? rscf_bit(B_WATCHDOG_TIMEOUT_FLAG) : RCC_ZERO);

  // a write only stores bits, it never feeds the sequencer
  assign base_v = wr_hit ? (WDATA_I & RCC_IMPL) : rcc_r;

  // set wins over any clear in the same cycle
  assign rcc_nxt = ((base_v & ~clr_v) | set_v) & RCC_IMPL;

  // ==========================================================
  // release sequencer
  // regulator off means the long power-up timer replaces the short start-up
  assign start_cyc = REGULATOR_ENABLE_I ? RSCF_CW'(TSTART_CYC) : RSCF_CW'(POWER_UP_TIMER_CYC);
  assign long_load = RSCF_CW'(TPOR_CYC) + start_cyc - CNT_ONE;
  assign trst_load = RSCF_CW'(TRST_CYC) - CNT_ONE;

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_LOAD:
      begin
        cnt_nxt = long_load;
        state_nxt = ST_PWR;
      end
      ST_PWR:
      begin
        if (cnt_r == CNT_ZERO)
        begin
          cnt_nxt = trst_load;
          state_nxt = ST_HOLD;
        end
        else
        begin
          cnt_nxt = cnt_r - CNT_ONE;
        end
      end
      ST_HOLD:
      begin
        if (cnt_r == CNT_ZERO)
        begin
          state_nxt = ST_RUN;
        end
        else
        begin
          cnt_nxt = cnt_r - CNT_ONE;
        end
      end
      ST_RUN:
      begin
        state_nxt = ST_RUN;
      end
      default:
      begin
        state_nxt = ST_LOAD;
      end
    endcase
    // a source still active keeps reloading, so timing starts at its release
    if (BROWN_OUT_RESET_I)
    begin
      state_nxt = ST_LOAD;
    end
    else if (hold_src && (state_r == ST_HOLD || state_r == ST_RUN))
    begin
      state_nxt = ST_HOLD;
      cnt_nxt = trst_load;
    end
  end

  assign sys_rst_nxt = any_src || (state_nxt != ST_RUN);
  assign wdt_en_nxt = WATCHDOG_FUSE_ENABLE_I | rcc_r[B_WDTEN];
  assign rdata_nxt = rd_hit ? rcc_r : RCC_ZERO;

  // ==========================================================
  // registers
  // the synchronous reset is the power-on event for this block
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESETN_I)
    begin
      rcc_r <= RCC_POR_VAL;
      state_r <= ST_LOAD;
      cnt_r <= CNT_ZERO;
    end
    else if (CE_I)
    begin
      rcc_r <= rcc_nxt;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // watchdog enable leaves reset on, as the fuse is not yet sampled
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESETN_I)
    begin
      sys_rst_r <= 1'b1;
      wdt_en_r <= 1'b1;
      vreg_r <= 1'b0;
      rdata_r <= RCC_ZERO;
    end
    else if (CE_I)
    begin
      sys_rst_r <= sys_rst_nxt;
      wdt_en_r <= wdt_en_nxt;
      vreg_r <= rcc_r[B_VREG];
      rdata_r <= rdata_nxt;
    end
  end

  assign SYSTEM_RESET_OUT_O = sys_rst_r;
  assign WATCHDOG_ENABLE_O = wdt_en_r;
  assign REGULATOR_SLEEP_KEEP_O = vreg_r;
  assign RDATA_O = rdata_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RESETN_I);

  AST_ANY_SRC: assert property (CE_I && any_src |=> SYSTEM_RESET_OUT_O)
    else $error("source active but system reset low");

  AST_SIMUL: assert property (CE_I && TRAP_CONFLICT_I && WATCHDOG_TIMEOUT_I |=>
    rcc_r[B_TRAP] && rcc_r[B_WATCHDOG_TIMEOUT_FLAG])
    else $error("simultaneous sources not both flagged");

  AST_POR_VAL: assert property (disable iff (1'b0) !RESETN_I |=> rcc_r == RCC_POR_VAL)
    else $error("cause register wrong after power-on");

  AST_POR_READ: assert property (!$past(RESETN_I, 2) && CE_I && rd_hit && !any_src
    |=> RDATA_O == RCC_POR_VAL)
    else $error("first read after power-on not 0x0003");

  AST_WR_NORST: assert property (CE_I && wr_hit && !any_src && state_r == ST_RUN
    |=> !SYSTEM_RESET_OUT_O && (rcc_r == ((($past(WDATA_I) & RCC_IMPL) & ~$past(clr_v)) | $past(set_v))))
    else $error("write caused reset or did not store");

  AST_TRAP_SET: assert property (CE_I && TRAP_CONFLICT_I |=> rcc_r[B_TRAP])
    else $error("trap flag not set");

  AST_BAD_CLR: assert property (CE_I && BROWN_OUT_RESET_I && !BAD_OPERATION_I
    |=> !rcc_r[B_BAD])
    else $error("bad operation flag survived brown-out");

  AST_EXT_KEEP: assert property (CE_I && BROWN_OUT_RESET_I && !wr_hit && rcc_r[B_EXT]
    |=> rcc_r[B_EXT])
    else $error("pin flag cleared by brown-out");

  AST_SWR_CLR: assert property (CE_I && BROWN_OUT_RESET_I && !RESET_INSTR_I
    |=> !rcc_r[B_SWR])
    else $error("software reset flag survived brown-out");

  AST_WATCHDOG_TIMEOUT_FLAG_CLR: assert property (CE_I && power_saving_instruction && !WATCHDOG_TIMEOUT_I
    |=> !rcc_r[B_WATCHDOG_TIMEOUT_FLAG])
    else $error("watchdog flag not cleared by power-saving");

  AST_SLEEP_SET: assert property (CE_I && POWER_SAVING_SLEEP_I |=> rcc_r[B_SLEEP])
    else $error("sleep flag not set");

  AST_IDLE_SET: assert property (CE_I && POWER_SAVING_IDLE_I |=> rcc_r[B_IDLE])
    else $error("idle flag not set");

  AST_BOR_KEEP: assert property (CE_I && !wr_hit && rcc_r[B_BOR] |=> rcc_r[B_BOR])
    else $error("brown-out flag cleared by hardware");

  AST_WDT_EN: assert property (CE_I && WATCHDOG_FUSE_ENABLE_I |=> WATCHDOG_ENABLE_O)
    else $error("fuse does not force watchdog on");

  AST_VREG: assert property (CE_I |=> REGULATOR_SLEEP_KEEP_O == $past(rcc_r[B_VREG]))
    else $error("regulator output does not follow control bit");

  AST_RSVD: assert property (RDATA_O[13:9] == 5'h00 && rcc_r[13:9] == 5'h00)
    else $error("unimplemented bits not zero");

  AST_CTRL_KEEP: assert property (CE_I && any_src && !wr_hit
    |=> rcc_r[B_VREG] == $past(rcc_r[B_VREG]) && rcc_r[B_WDTEN] == $past(rcc_r[B_WDTEN]))
    else $error("control bit changed by reset");

  AST_HOLD: assert property (CE_I && hold_src && !BROWN_OUT_RESET_I && state_r == ST_RUN
    |=> SYSTEM_RESET_OUT_O [*8])
    else $error("short reset released too early");

  AST_PWR: assert property (state_r == ST_PWR || state_r == ST_LOAD |-> SYSTEM_RESET_OUT_O)
    else $error("released during power-up delay");

  AST_RELEASE: assert property ($fell(SYSTEM_RESET_OUT_O) |-> state_r == ST_RUN
    && $past(state_r) == ST_HOLD && $past(cnt_r) == CNT_ZERO)
    else $error("release not at end of hold count");

  // ==========================================================
  // flag checks
  AST_BAD_SET: assert property (CE_I && BAD_OPERATION_I |=> rcc_r[B_BAD])
    else $error("bad operation flag not set");

  AST_EXT_SET: assert property (CE_I && MASTER_CLEAR_PIN_I |=> rcc_r[B_EXT])
    else $error("pin flag not set");

  AST_SWR_SET: assert property (CE_I && RESET_INSTR_I |=> rcc_r[B_SWR])
    else $error("software reset flag not set");

  AST_WATCHDOG_TIMEOUT_FLAG_SET: assert property (CE_I && WATCHDOG_TIMEOUT_I |=> rcc_r[B_WATCHDOG_TIMEOUT_FLAG])
    else $error("watchdog flag not set");

  AST_BOR_SET: assert property (CE_I && BROWN_OUT_RESET_I |=> rcc_r[B_BOR])
    else $error("brown-out flag not set");

  AST_TRAP_CLR: assert property (CE_I && BROWN_OUT_RESET_I && !TRAP_CONFLICT_I
    |=> !rcc_r[B_TRAP])
    else $error("trap flag survived brown-out");

  AST_SLEEP_CLR: assert property (CE_I && BROWN_OUT_RESET_I && !POWER_SAVING_SLEEP_I
    |=> !rcc_r[B_SLEEP])
    else $error("sleep flag survived brown-out");

  AST_IDLE_CLR: assert property (CE_I && BROWN_OUT_RESET_I && !POWER_SAVING_IDLE_I
    |=> !rcc_r[B_IDLE])
    else $error("idle flag survived brown-out");

  AST_POR_KEEP: assert property (CE_I && !wr_hit && rcc_r[B_POR] |=> rcc_r[B_POR])
    else $error("power-on flag cleared by hardware");

  AST_WDT_OFF: assert property (CE_I && !WATCHDOG_FUSE_ENABLE_I && !rcc_r[B_WDTEN]
    |=> !WATCHDOG_ENABLE_O)
    else $error("watchdog on although fuse and control bit are off");

  AST_RD_DATA: assert property (CE_I && rd_hit |=> RDATA_O == $past(rcc_r))
    else $error("read data does not match register");

  AST_RD_IDLE: assert property (CE_I && !rd_hit |=> RDATA_O == RCC_ZERO)
    else $error("read data not zero outside a read");

  // ==========================================================
  // sequencer checks
  AST_BOR_SYS: assert property (CE_I && BROWN_OUT_RESET_I |=> state_r == ST_LOAD && SYSTEM_RESET_OUT_O)
    else $error("brown-out did not restart power-up");

  AST_RUN_QUIET: assert property (CE_I && state_r == ST_RUN && !any_src
    |=> !SYSTEM_RESET_OUT_O)
    else $error("system reset raised with no source");

  AST_HOLD_LOAD: assert property (CE_I && hold_src && !BROWN_OUT_RESET_I && state_r == ST_RUN
    |=> state_r == ST_HOLD && cnt_r == RSCF_CW'(TRST_CYC - 1))
    else $error("hold count not loaded");

  AST_PWR_LOAD: assert property (CE_I && state_r == ST_LOAD && !BROWN_OUT_RESET_I
    |=> state_r == ST_PWR)
    else $error("power-up delay did not start");

  AST_CNT_DOWN: assert property (CE_I && state_r == ST_PWR && cnt_r != CNT_ZERO && !BROWN_OUT_RESET_I
    |=> state_r == ST_PWR && cnt_r == $past(cnt_r) - CNT_ONE)
    else $error("power-up count did not step down");

  AST_FREEZE: assert property (!CE_I
    |=> $stable(rcc_r) && $stable(state_r) && $stable(SYSTEM_RESET_OUT_O))
    else $error("state moved while clock enable low");

  // ==========================================================
  // cover points
  COV_BOR_REL: cover property ($fell(SYSTEM_RESET_OUT_O) && rcc_r[B_BOR]);
  COV_POR_REL: cover property ($fell(SYSTEM_RESET_OUT_O) && rcc_r[B_POR]);
  COV_PIN_RST: cover property (state_r == ST_RUN && MASTER_CLEAR_PIN_I ##1 state_r == ST_HOLD);
  COV_WR_RD: cover property (wr_hit ##1 rd_hit);
  COV_SLEEP_WDT: cover property (rcc_r[B_WATCHDOG_TIMEOUT_FLAG] && POWER_SAVING_SLEEP_I);
endmodule // rscf_top

//--- shared/rscf_pkg.sv
package rscf_pkg;
  // ==========================================================
  // bus and register layout
  localparam int RSCF_AW = 4;
  localparam int RSCF_DW = 16;
  localparam int RSCF_CW = 24;
  localparam logic [3:0] RCC_OFS = 4'h0;
  localparam int B_TRAP = 15;
  localparam int B_BAD = 14;
  localparam int B_VREG = 8;
  localparam int B_EXT = 7;
  localparam int B_SWR = 6;
  localparam int B_WDTEN = 5;
  localparam int B_WATCHDOG_TIMEOUT_FLAG = 4;
  localparam int B_SLEEP = 3;
  localparam int B_IDLE = 2;
  localparam int B_BOR = 1;
  localparam int B_POR = 0;
  localparam logic [15:0] RCC_POR_VAL = 16'h0003;
  localparam logic [15:0] RCC_IMPL = 16'hC1FF;
  localparam logic [15:0] RCC_BOR_CLR = 16'hC05C;
  localparam logic [15:0] RCC_ZERO = 16'h0000;
  // ==========================================================
  // timing
  localparam int CLK_MHZ = 200;
  localparam int TPOR_US = 10;
  localparam int TSTART_US = 20;
  localparam int TRST_US = 20;
  localparam int POWER_UP_TIMER_MS = 64;
  localparam int TPOR_CYC = TPOR_US * CLK_MHZ;
  localparam int TSTART_CYC = TSTART_US * CLK_MHZ;
  localparam int TRST_CYC = TRST_US * CLK_MHZ;
  localparam int POWER_UP_TIMER_CYC_DEF = POWER_UP_TIMER_MS * 1000 * CLK_MHZ;
  localparam logic [RSCF_CW-1:0] CNT_ZERO = 24'h000000;
  localparam logic [RSCF_CW-1:0] CNT_ONE = 24'h000001;
  // ==========================================================
  // sequencer states
  typedef enum logic [1:0] {ST_LOAD, ST_PWR, ST_HOLD, ST_RUN} rscf_state_t;

  function automatic logic [15:0] rscf_bit(input int b);
    rscf_bit = 16'h0001 << b;
  endfunction
endpackage

//--- testbench/rscf_src_model.sv
// ==========================================================
// reset sources and core events: one-cycle pulses on request
module rscf_src_model
(
  // clock
  input wire logic clk_i,
  // event lines toward the combiner
  output logic bad_o,
  output logic trap_o,
  output logic wdt_o,
  output logic instr_o,
  output logic pin_o,
  output logic bor_o,
  output logic idle_o,
  output logic sleep_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ev_r = 8'h00;
  assign {bad_o, trap_o, wdt_o, instr_o, pin_o, bor_o, idle_o, sleep_o} = ev_r;
  // raised after an edge, sampled and dropped at the next edge
  // events never linger, so a stale level cannot fake a second reset
  task automatic fire(input logic [7:0] m);
    @(posedge clk_i);
    ev_r <= m;
    @(posedge clk_i);
    ev_r <= 8'h00;
  endtask
endmodule // rscf_src_model

//--- testbench/rscf_top_tb_top.sv
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s exp=%h got=%h", nm, e, g); end end
// ==========================================================
// bench top
module rscf_top_tb_top;
  import rscf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, fuse = 1'b0, wr = 1'b0, rd = 1'b0, regen = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wd = 16'h0000, rdat, d;
  logic sys, wden, vkeep, bad, trap, wdt, instr, pin, bor, idle, sleep;
  int fails = 0, checked = 0, cycles = 0, n;
  logic [7:0] msk [5] = '{8'h40, 8'h80, 8'h08, 8'h10, 8'h20};
  logic [15:0] flg [5] = '{16'h8000, 16'h4000, 16'h0080, 16'h0040, 16'h0010};
  always #2.5 clk = ~clk;
  rscf_src_model m (.clk_i(clk), .bad_o(bad), .trap_o(trap), .wdt_o(wdt), .instr_o(instr),
    .pin_o(pin), .bor_o(bor), .idle_o(idle), .sleep_o(sleep));
  rscf_top #(.POWER_UP_TIMER_CYC(50)) dut (.CLOCK_I(clk), .RESETN_I(rstn), .CE_I(ce),
    .BROWN_OUT_RESET_I(bor), .MASTER_CLEAR_PIN_I(pin), .RESET_INSTR_I(instr),
    .WATCHDOG_TIMEOUT_I(wdt), .TRAP_CONFLICT_I(trap), .BAD_OPERATION_I(bad),
    .POWER_SAVING_SLEEP_I(sleep), .POWER_SAVING_IDLE_I(idle),
    .WATCHDOG_FUSE_ENABLE_I(fuse), .REGULATOR_ENABLE_I(regen), .ADDR_I(addr), .WDATA_I(wd),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdat), .SYSTEM_RESET_OUT_O(sys),
    .WATCHDOG_ENABLE_O(wden), .REGULATOR_SLEEP_KEEP_O(vkeep));
  task automatic tally_and_finish();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdat;
  endtask
  // counts cycles until the system reset drops, bounded
  task automatic hold_len(output int c);
    c = 0;
    repeat (12000)
    begin
      @(posedge clk);
      #1;
      if (sys === 1'b0 && c > 0)
        break;
      if (sys === 1'b1)
        c++;
    end
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fails++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd16(RCC_OFS, d);
    `CHK("por value", RCC_POR_VAL, d)
    hold_len(n);
    `CHK("por hold", 1'b1, n >= TPOR_CYC + 50 + TRST_CYC - 2 && n <= TPOR_CYC + 50 + TRST_CYC + 2)
    wr16(RCC_OFS, 16'hFFFF);
    rd16(RCC_OFS, d);
    `CHK("write all", RCC_IMPL, d)
    `CHK("no reset on write", 1'b0, sys)
    `CHK("wdt on", 1'b1, wden)
    `CHK("vreg keep", 1'b1, vkeep)
    wr16(RCC_OFS, RCC_ZERO);
    rd16(RCC_OFS, d);
    `CHK("wdt off", 1'b0, wden)
    `CHK("vreg standby", 1'b0, vkeep)
    fuse <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("fuse forces wdt", 1'b1, wden)
    wr16(4'h3, 16'hFFFF);
    rd16(4'h3, d);
    `CHK("unmapped read", RCC_ZERO, d)
    ce <= 1'b0;
    wr16(RCC_OFS, 16'h0040);
    ce <= 1'b1;
    rd16(RCC_OFS, d);
    `CHK("unmapped or frozen write", RCC_ZERO, d)
    for (int i = 0; i < 5; i++)
    begin
      wr16(RCC_OFS, RCC_ZERO);
      m.fire(msk[i]);
      hold_len(n);
      // the first held cycle passes inside fire, before hold_len starts counting
      `CHK("source hold", TRST_CYC, n + 1)
      rd16(RCC_OFS, d);
      `CHK("source flag", flg[i], d)
    end
    wr16(RCC_OFS, RCC_ZERO);
    m.fire(8'h68);
    hold_len(n);
    rd16(RCC_OFS, d);
    `CHK("joint flags", 16'h8090, d)
    wr16(RCC_OFS, 16'h0010);
    m.fire(8'h01);
    rd16(RCC_OFS, d);
    `CHK("sleep flag", 16'h0008, d)
    wr16(RCC_OFS, 16'h0010);
    m.fire(8'h02);
    rd16(RCC_OFS, d);
    `CHK("idle flag", 16'h0004, d)
    `CHK("no reset on sleep", 1'b0, sys)
    wr16(RCC_OFS, 16'hC1FC);
    m.fire(8'h04);
    // count first: a read here would eat held cycles from the count
    hold_len(n);
    `CHK("bor hold", 1'b1, n >= TPOR_CYC + 50 + TRST_CYC - 2 && n <= TPOR_CYC + 50 + TRST_CYC + 2)
    rd16(RCC_OFS, d);
    `CHK("brown-out flags", 16'h01A2, d)
    wr16(RCC_OFS, 16'h0180);
    rd16(RCC_OFS, d);
    `CHK("soft clear of bor", 16'h0180, d)
    regen <= 1'b1;
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    rd16(RCC_OFS, d);
    `CHK("second por", RCC_POR_VAL, d)
    `CHK("por vreg", 1'b0, vkeep)
    hold_len(n);
    `CHK("regulator hold", 1'b1, n >= TPOR_CYC + TSTART_CYC + TRST_CYC - 2 && n <= TPOR_CYC + TSTART_CYC + TRST_CYC + 2)
    tally_and_finish();
  end
endmodule // rscf_top_tb_top
